// File: design/fft_pkg.sv
// Constants, state layout and enumerations of the fall-through FIFO flag block
// Assumes the 16,384 x 9 organization and one 40 MHz system clock
//
// Overview of operation
// - Fall-through: first word into empty FIFO drives output ready low.
// - Fall-through: almost empty rises at empty offset plus two words.
// - Fall-through: half full goes low from word 8,194 onward.
// - Fall-through: almost full goes low at 16,385 minus full offset words.
// - Fall-through: input ready goes high and blocks writes at 16,385 words.
// - Read from full clears input ready; later reads raise almost full, half full.
// - Fall-through: almost empty goes low at empty offset plus one words.
// - Last word read raises output ready; reads while empty are ignored.
// - Output ready passes three read clock stages, input ready two write stages.
// - Load select high at master reset: serial loading, both offsets 3FF.
// - Load select low at master reset: parallel loading, both offsets 07F.
// - Offsets read back only through the parallel path, never serially.
// - Offsets may be programmed or reprogrammed any time after master reset.
// - Standard mode flags follow the plain depth thresholds.
// - Parallel write steps empty low, empty high, full low, full high.
// - Parallel read steps empty low, empty high, full low, full high.
// - Serial shift loads 28 bits, empty offset LSB first, full MSB last.
// - Loading method is fixed at master reset only.
// - Parallel readback works under either method and either timing mode.
// - Timing mode latched at master reset: pin low standard, high fall-through.
// - Fall-through: first word reaches the outputs after three read clock rises.
// - Master reset homes both offset pointers; partial reset leaves them.
package fft_pkg;
	localparam int DATA_W   = 9;
	localparam int ADDR_W   = 14;
	localparam int LVL_W    = 15;
	localparam int OFF_W    = 14;
	localparam int OFF_LO_W = 9;
	localparam int OFF_HI_W = 5;
	localparam int SER_W    = 5;
	localparam int PIN_W    = 18;
	localparam int PIN_MRS  = 17;
	localparam int PIN_PRS  = 16;
	localparam int PIN_WCLK = 15;
	localparam int PIN_RCLK = 14;
	localparam int PIN_WEN  = 13;
	localparam int PIN_REN  = 12;
	localparam int PIN_LD   = 11;
	localparam int PIN_SEN  = 10;
	localparam int PIN_SI   = 9;

	localparam logic [LVL_W-1:0] MEM_DEPTH   = 15'h4000;
	localparam logic [LVL_W-1:0] HALF_DEPTH  = 15'h2000;
	localparam logic [OFF_W-1:0] OFF_DEF_SER = 14'h03FF;
	localparam logic [OFF_W-1:0] OFF_DEF_PAR = 14'h007F;
	localparam logic [SER_W-1:0] SER_LAST    = 5'h1B;
	localparam logic [1:0]       FT_LAST     = 2'h2;

	typedef enum logic [1:0] {OFF_EMPTY_LO, OFF_EMPTY_HI, OFF_FULL_LO, OFF_FULL_HI} fft_off_sel_t;

	typedef struct packed {
		logic               first_word_fall_through;
		logic               ser_method;
		logic [OFF_W-1:0]   empty_off;
		logic [OFF_W-1:0]   full_off;
		fft_off_sel_t       owptr;
		fft_off_sel_t       orptr;
		logic [SER_W-1:0]   sptr;
		logic               wclk_d;
		logic               rclk_d;
		logic [ADDR_W-1:0]  wr_ptr;
		logic [ADDR_W-1:0]  rd_ptr;
		logic [LVL_W-1:0]   level;
		logic               oreg_valid;
		logic [1:0]         ft_cnt;
		logic [DATA_W-1:0]  dout;
		logic               rd_stage;
		logic               wr_stage;
		logic               or_n;
		logic               ir_n;
		logic               ef_n;
		logic               ff_n;
		logic               pae_n;
		logic               paf_n;
		logic               hf_n;
	} fft_state_t;

	localparam fft_state_t ST_RESET = '{first_word_fall_through: 1'b0, ser_method: 1'b0,
		empty_off: OFF_DEF_PAR, full_off: OFF_DEF_PAR, owptr: OFF_EMPTY_LO,
		orptr: OFF_EMPTY_LO, sptr: 5'h00, wclk_d: 1'b0, rclk_d: 1'b0,
		wr_ptr: 14'h0000, rd_ptr: 14'h0000, level: 15'h0000, oreg_valid: 1'b0,
		ft_cnt: 2'h0, dout: 9'h000, rd_stage: 1'b0, wr_stage: 1'b0, or_n: 1'b1,
		ir_n: 1'b1, ef_n: 1'b0, ff_n: 1'b1, pae_n: 1'b0, paf_n: 1'b1, hf_n: 1'b1};
endpackage

// File: design/fft_mem_if.sv
// Port bundle between the flag controller and its word memory
// Assumes both ends run on the same system clock
`timescale 1ns/1ps
interface fft_mem_if;
	import fft_pkg::*;
	logic                we;
	logic [ADDR_W-1:0]   waddr;
	logic [DATA_W-1:0]   wdata;
	logic [ADDR_W-1:0]   raddr;
	logic [DATA_W-1:0]   rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport ram (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: design/fft_sync.sv
// Two-flop synchroniser for the pin inputs
// Assumes inputs are asynchronous to clk_i; only the second stage is read
`timescale 1ns/1ps
module fft_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fft_sync_t;

	fft_sync_t st_reg, st_next;

	always_comb begin
		st_next.s1 = async_i;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_o = st_reg.s2;
endmodule // fft_sync

// File: design/fft_mem.sv
// Word memory with registered, write-first read data
// Assumes one write port and one read port on the system clock
`timescale 1ns/1ps
module fft_mem
	import fft_pkg::*;
(
	input  wire logic clk_i,
	fft_mem_if.ram    mem_port
);
	logic [DATA_W-1:0] ram [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rdata_reg;

	always_ff @(posedge clk_i) begin
		if (mem_port.we) begin
			ram[mem_port.waddr] <= mem_port.wdata;
		end
		if (mem_port.we && (mem_port.waddr == mem_port.raddr)) begin
			rdata_reg <= mem_port.wdata;
		end else begin
			rdata_reg <= ram[mem_port.raddr];
		end
	end

	assign mem_port.rdata = rdata_reg;
endmodule // fft_mem

// File: design/fft_flags_top.sv
// Flag and offset-programming logic of a two-clock 9-bit FIFO
// Assumes write and read clocks are pins sampled by clk_i, far slower than it
//
`timescale 1ns/1ps
module fft_flags_top
	import fft_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              master_reset_n_i,
	input  wire logic              partial_reset_n_i,
	input  wire logic              write_clock_i,
	input  wire logic              read_clock_i,
	input  wire logic              write_enable_n_i,
	input  wire logic              read_enable_n_i,
	input  wire logic              offset_load_select_n_i,
	input  wire logic              serial_enable_n_i,
	input  wire logic              mode_serial_input_pin_i,
	input  wire logic [DATA_W-1:0] write_data_in_i,
	output logic      [DATA_W-1:0] read_data_out_o,
	output logic                   output_ready_n_o,
	output logic                   input_ready_n_o,
	output logic                   empty_flag_n_o,
	output logic                   full_flag_n_o,
	output logic                   almost_empty_flag_n_o,
	output logic                   almost_full_flag_n_o,
	output logic                   half_full_flag_n_o,
	output logic                   first_word_fall_through_o
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [LVL_W-1:0] widen(input logic [OFF_W-1:0] v);
		return {1'b0, v};
	endfunction

	function automatic logic [LVL_W-1:0] bit_lvl(input logic b);
		return {{(LVL_W-1){1'b0}}, b};
	endfunction

	function automatic logic [DATA_W-1:0] off_field(input fft_off_sel_t sel,
		input logic [OFF_W-1:0] e, input logic [OFF_W-1:0] f);
		logic [DATA_W-1:0] r;
		case (sel)
			OFF_EMPTY_LO: r = e[OFF_LO_W-1:0];
			OFF_EMPTY_HI: r = {{(DATA_W-OFF_HI_W){1'b0}}, e[OFF_W-1:OFF_LO_W]};
			OFF_FULL_LO:  r = f[OFF_LO_W-1:0];
			OFF_FULL_HI:  r = {{(DATA_W-OFF_HI_W){1'b0}}, f[OFF_W-1:OFF_LO_W]};
			default:      r = '0;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Pin sampling and memory
	// ----------------------------------------------------------------
	fft_state_t        st_reg;
	fft_state_t        st_next;
	logic [PIN_W-1:0]  pins_s;
	fft_mem_if         mem_bus ();

	fft_sync #(.W(PIN_W)) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.async_i ({master_reset_n_i, partial_reset_n_i, write_clock_i, read_clock_i,
			write_enable_n_i, read_enable_n_i, offset_load_select_n_i,
			serial_enable_n_i, mode_serial_input_pin_i, write_data_in_i}),
		.sync_o  (pins_s)
	);

	fft_mem u_mem (
		.clk_i    (clk_i),
		.mem_port (mem_bus.ram)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic              mrs;
	logic              prs;
	logic              quiet;
	logic              wrise;
	logic              rrise;
	logic              wen;
	logic              ren;
	logic              ld;
	logic              serial_enable;
	logic              fw;
	logic [LVL_W-1:0]  full_lvl;
	logic [LVL_W-1:0]  pae_lvl;
	logic [LVL_W-1:0]  hf_lvl;
	logic [LVL_W-1:0]  paf_lvl;
	logic [LVL_W-1:0]  ram_words;
	logic [LVL_W-1:0]  level_new;
	logic              full_now;
	logic              full_new;
	logic              wr_ev;
	logic              rd_ev;
	logic              ft_step;
	logic              ft_load;
	logic              ram_pop;
	logic              par_wr;
	logic              par_rd;
	logic              ser_wr;

	assign mrs       = ~pins_s[PIN_MRS];
	assign prs       = ~pins_s[PIN_PRS];
	assign quiet     = ~mrs & ~prs;
	assign wrise     = pins_s[PIN_WCLK] & ~st_reg.wclk_d;
	assign rrise     = pins_s[PIN_RCLK] & ~st_reg.rclk_d;
	assign wen       = ~pins_s[PIN_WEN];
	assign ren       = ~pins_s[PIN_REN];
	assign ld        = ~pins_s[PIN_LD];
	assign serial_enable       = ~pins_s[PIN_SEN];
	assign fw        = st_reg.first_word_fall_through;
	assign full_lvl  = MEM_DEPTH + bit_lvl(fw);
	assign pae_lvl   = widen(st_reg.empty_off) + 15'h0001 + bit_lvl(fw);
	assign hf_lvl    = HALF_DEPTH + 15'h0001 + bit_lvl(fw);
	assign paf_lvl   = full_lvl - widen(st_reg.full_off);
	assign ram_words = st_reg.level - bit_lvl(fw & st_reg.oreg_valid);
	assign full_now  = st_reg.level >= full_lvl;
	assign wr_ev     = quiet & wrise & wen & ~ld & ~full_now;
	assign rd_ev     = quiet & rrise & ren & ~ld
		& (fw ? st_reg.oreg_valid : (st_reg.level != 15'h0000));
	assign ft_step   = quiet & rrise & fw & ~st_reg.oreg_valid & (ram_words != 15'h0000);
	assign ft_load   = ft_step & (st_reg.ft_cnt == FT_LAST);
	assign ram_pop   = fw ? ((rd_ev & (ram_words != 15'h0000)) | ft_load) : rd_ev;
	assign level_new = st_reg.level + bit_lvl(wr_ev) - bit_lvl(rd_ev);
	assign full_new  = level_new >= full_lvl;
	assign par_wr    = quiet & wrise & ld & wen & ~ren & ~serial_enable & ~st_reg.ser_method;
	assign par_rd    = quiet & rrise & ld & ren & ~wen & ~serial_enable;
	assign ser_wr    = quiet & wrise & ld & serial_enable & ~wen & ~ren & st_reg.ser_method;

	assign mem_bus.we    = wr_ev;
	assign mem_bus.waddr = st_reg.wr_ptr;
	assign mem_bus.wdata = pins_s[DATA_W-1:0];
	assign mem_bus.raddr = st_reg.rd_ptr;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [2*OFF_W-1:0] offs;
		offs = {st_reg.full_off, st_reg.empty_off};
		st_next = st_reg;
		st_next.wclk_d = pins_s[PIN_WCLK];
		st_next.rclk_d = pins_s[PIN_RCLK];
		st_next.level = level_new;
		if (wr_ev) begin
			st_next.wr_ptr = st_reg.wr_ptr + 14'h0001;
		end
		if (ram_pop) begin
			st_next.rd_ptr = st_reg.rd_ptr + 14'h0001;
			st_next.dout = mem_bus.rdata;
		end
		if (fw) begin
			if (ft_step) begin
				st_next.ft_cnt = st_reg.ft_cnt + 2'h1;
			end
			if (ft_load) begin
				st_next.oreg_valid = 1'b1;
				st_next.or_n = 1'b0;
				st_next.ft_cnt = 2'h0;
			end
			if (rd_ev && (ram_words == 15'h0000)) begin
				st_next.oreg_valid = 1'b0;
				st_next.or_n = 1'b1;
			end
			if (wrise) begin
				st_next.wr_stage = full_new;
				st_next.ir_n = full_new | st_reg.wr_stage;
			end
		end else begin
			if (rrise) begin
				st_next.rd_stage = level_new != 15'h0000;
				st_next.ef_n = (level_new != 15'h0000) & st_reg.rd_stage;
			end
			if (wrise) begin
				st_next.wr_stage = full_new;
				st_next.ff_n = ~(full_new | st_reg.wr_stage);
			end
		end
		st_next.pae_n = level_new >= pae_lvl;
		st_next.hf_n = ~(level_new >= hf_lvl);
		st_next.paf_n = ~(level_new >= paf_lvl);
		if (par_wr) begin
			case (st_reg.owptr)
				OFF_EMPTY_LO: offs[OFF_LO_W-1:0] = pins_s[OFF_LO_W-1:0];
				OFF_EMPTY_HI: offs[OFF_W-1:OFF_LO_W] = pins_s[OFF_HI_W-1:0];
				OFF_FULL_LO:  offs[OFF_W+OFF_LO_W-1:OFF_W] = pins_s[OFF_LO_W-1:0];
				OFF_FULL_HI:  offs[2*OFF_W-1:OFF_W+OFF_LO_W] = pins_s[OFF_HI_W-1:0];
				default:      offs = offs;
			endcase
			st_next.owptr = fft_off_sel_t'(st_reg.owptr + 2'h1);
		end
		if (ser_wr) begin
			offs[st_reg.sptr] = pins_s[PIN_SI];
			st_next.sptr = (st_reg.sptr == SER_LAST) ? 5'h00 : st_reg.sptr + 5'h01;
		end
		st_next.empty_off = offs[OFF_W-1:0];
		st_next.full_off = offs[2*OFF_W-1:OFF_W];
		if (par_rd) begin
			st_next.dout = off_field(st_reg.orptr, st_reg.empty_off, st_reg.full_off);
			st_next.orptr = fft_off_sel_t'(st_reg.orptr + 2'h1);
		end
		if (mrs || prs) begin
			st_next = ST_RESET;
			st_next.wclk_d = pins_s[PIN_WCLK];
			st_next.rclk_d = pins_s[PIN_RCLK];
			st_next.first_word_fall_through = st_reg.first_word_fall_through;
			st_next.ser_method = st_reg.ser_method;
			st_next.empty_off = st_reg.empty_off;
			st_next.full_off = st_reg.full_off;
			st_next.owptr = st_reg.owptr;
			st_next.orptr = st_reg.orptr;
			st_next.sptr = st_reg.sptr;
			if (mrs) begin
				st_next.first_word_fall_through = pins_s[PIN_SI];
				st_next.ser_method = pins_s[PIN_LD];
				st_next.empty_off = pins_s[PIN_LD] ? OFF_DEF_SER : OFF_DEF_PAR;
				st_next.full_off = pins_s[PIN_LD] ? OFF_DEF_SER : OFF_DEF_PAR;
				st_next.owptr = OFF_EMPTY_LO;
				st_next.orptr = OFF_EMPTY_LO;
				st_next.sptr = 5'h00;
			end
			st_next.ef_n = st_next.first_word_fall_through;
			st_next.ir_n = ~st_next.first_word_fall_through;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign read_data_out_o           = st_reg.dout;
	assign output_ready_n_o          = st_reg.or_n;
	assign input_ready_n_o           = st_reg.ir_n;
	assign empty_flag_n_o            = st_reg.ef_n;
	assign full_flag_n_o             = st_reg.ff_n;
	assign almost_empty_flag_n_o     = st_reg.pae_n;
	assign almost_full_flag_n_o      = st_reg.paf_n;
	assign half_full_flag_n_o        = st_reg.hf_n;
	assign first_word_fall_through_o = st_reg.first_word_fall_through;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking a_cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_last_read;
		fw && rd_ev && (ram_words == 15'h0000);
	endsequence

	sequence s_fill_up;
		fw && wr_ev && !rd_ev && (level_new == full_lvl);
	endsequence

	a_ft_latency: assert property ($fell(st_reg.or_n) |->
		$past(ft_load) && ($past(st_reg.ft_cnt) == 2'h2))
		else $error("output ready fell without three read clock rises");

	a_ir_on_full: assert property (s_fill_up |=> st_reg.ir_n && (st_reg.level == 15'h4001))
		else $error("input ready not high at full depth");

	a_no_overfill: assert property (quiet && full_now && !rd_ev |=>
		st_reg.level == $past(st_reg.level))
		else $error("write accepted while full");

	a_or_on_last: assert property (s_last_read |=> st_reg.or_n && !st_reg.oreg_valid)
		else $error("output ready not high after last read");

	a_empty_ignored: assert property (quiet && rrise && ren && !ld && (st_reg.level == 15'h0000)
		|=> st_reg.rd_ptr == $past(st_reg.rd_ptr))
		else $error("read taken from empty FIFO");

	a_pae_level: assert property (quiet |=> st_reg.pae_n == (st_reg.level >= $past(pae_lvl)))
		else $error("almost empty flag disagrees with word count");

	a_hf_level: assert property (quiet && fw |=> st_reg.hf_n == (st_reg.level < 15'h2002))
		else $error("half full flag disagrees with word count");

	a_paf_level: assert property (quiet |=> st_reg.paf_n == (st_reg.level < $past(paf_lvl)))
		else $error("almost full flag disagrees with word count");

	a_mrs_default: assert property (mrs |=> (st_reg.empty_off == st_reg.full_off)
		&& (st_reg.empty_off == ($past(pins_s[PIN_LD]) ? 14'h03FF : 14'h007F))
		&& (st_reg.owptr == OFF_EMPTY_LO))
		else $error("master reset did not load default offsets");

	a_par_wr_step: assert property (par_wr |=>
		st_reg.owptr == fft_off_sel_t'($past(st_reg.owptr) + 2'h1))
		else $error("offset write pointer did not advance");

	sequence s_fill_edge;
		fw && quiet && wrise && full_new;
	endsequence

	a_or_on_load: assert property (ft_load |=> !st_reg.or_n && st_reg.oreg_valid)
		else $error("output ready not low after first word");

	a_ft_count: assert property (ft_step && !ft_load |=>
		st_reg.ft_cnt == $past(st_reg.ft_cnt) + 2'h1)
		else $error("output stage counter did not advance");

	a_ir_stages: assert property (s_fill_edge |=> st_reg.ir_n && st_reg.wr_stage)
		else $error("input ready stages not set at full");

	a_ir_release: assert property (fw && quiet && wrise && !full_new && !st_reg.wr_stage
		|=> !st_reg.ir_n)
		else $error("input ready not low with room");

	a_empty_flag: assert property (!fw && quiet && rrise && (level_new == 15'h0000)
		|=> !st_reg.ef_n)
		else $error("empty flag not low at zero words");

	a_full_flag: assert property (!fw && quiet && wrise && full_new |=> !st_reg.ff_n)
		else $error("full flag not low at full depth");

	a_ser_step: assert property (ser_wr && (st_reg.sptr != SER_LAST) |=>
		st_reg.sptr == $past(st_reg.sptr) + 5'h01)
		else $error("serial bit pointer did not advance");

	a_ser_wrap: assert property (ser_wr && (st_reg.sptr == SER_LAST) |=>
		st_reg.sptr == 5'h00)
		else $error("serial bit pointer did not wrap");

	a_par_rd_step: assert property (par_rd |=>
		st_reg.orptr == fft_off_sel_t'($past(st_reg.orptr) + 2'h1))
		else $error("offset read pointer did not advance");

	a_method_kept: assert property (!mrs |=>
		(st_reg.ser_method == $past(st_reg.ser_method)) && (st_reg.first_word_fall_through == $past(st_reg.first_word_fall_through)))
		else $error("mode or method changed outside master reset");

	a_no_par_wr: assert property (quiet && wrise && ld && wen && st_reg.ser_method |=>
		st_reg.owptr == $past(st_reg.owptr))
		else $error("parallel offset write under serial method");

	a_mode_latch: assert property (mrs |=> st_reg.first_word_fall_through == $past(pins_s[PIN_SI]))
		else $error("timing mode not latched at master reset");

	a_prs_keeps: assert property (prs && !mrs |=>
		(st_reg.owptr == $past(st_reg.owptr)) && (st_reg.orptr == $past(st_reg.orptr)))
		else $error("partial reset moved an offset pointer");

	a_std_ready_idle: assert property (!fw && quiet |=>
		st_reg.or_n && st_reg.ir_n)
		else $error("ready flags active in standard mode");
endmodule // fft_flags_top

// File: tb/fft_link_model.sv
// Writer and reader logic that drives the link pins of the FIFO flag block
// Assumes clk_i is the system clock; link clocks rest low between frames
`timescale 1ns/1ps
module fft_link_model
	import fft_pkg::*;
(
	input  wire logic              clk_i,
	output logic                   write_clock_o,
	output logic                   read_clock_o,
	output logic                   write_enable_n_o,
	output logic                   read_enable_n_o,
	output logic                   offset_load_select_n_o,
	output logic                   serial_enable_n_o,
	output logic                   serial_input_o,
	output logic      [DATA_W-1:0] write_data_o
);
	// ----------------------------------------
	// Pin driving
	// ----------------------------------------
	initial begin
		{write_clock_o, read_clock_o, serial_input_o} = 3'h0;
		{write_enable_n_o, read_enable_n_o, offset_load_select_n_o, serial_enable_n_o} = 4'hF;
		write_data_o = 9'h000;
	end

	// Static pins seen at master reset
	task automatic setup(input logic ld_n, input logic si);
		@(posedge clk_i);
		offset_load_select_n_o <= ld_n;
		serial_input_o         <= si;
	endtask

	// One link clock frame: pins settle, clock high, pins released
	task automatic pulse(input logic wr, input logic ld_n, input logic we_n,
		input logic re_n, input logic se_n, input logic si, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		offset_load_select_n_o <= ld_n;
		write_enable_n_o       <= we_n;
		read_enable_n_o        <= re_n;
		serial_enable_n_o      <= se_n;
		serial_input_o         <= si;
		write_data_o           <= d;
		repeat (2) @(posedge clk_i);
		if (wr) begin
			write_clock_o <= 1'b1;
		end else begin
			read_clock_o <= 1'b1;
		end
		repeat (4) @(posedge clk_i);
		write_clock_o <= 1'b0;
		read_clock_o  <= 1'b0;
		@(posedge clk_i);
		write_enable_n_o  <= 1'b1;
		read_enable_n_o   <= 1'b1;
		serial_enable_n_o <= 1'b1;
		serial_input_o    <= ~si;
		write_data_o      <= ~d;
	endtask
endmodule // fft_link_model

// File: tb/fft_flags_top_tb.sv
// Self-checking bench for the FIFO flag and offset-programming block
// Assumes the link model drives every link pin; this module owns the resets
`timescale 1ns/1ps
module fft_flags_top_tb;
	import fft_pkg::*;
	logic              clk_i             = 1'b0;
	logic              reset_i           = 1'b1;
	logic              master_reset_n_i  = 1'b1;
	logic              partial_reset_n_i = 1'b1;
	logic              write_clock_i, read_clock_i, write_enable_n_i, read_enable_n_i;
	logic              offset_load_select_n_i, serial_enable_n_i, mode_serial_input_pin_i;
	logic [DATA_W-1:0] write_data_in_i, read_data_out_o;
	logic              output_ready_n_o, input_ready_n_o, empty_flag_n_o, full_flag_n_o;
	logic              almost_empty_flag_n_o, almost_full_flag_n_o, half_full_flag_n_o;
	logic              first_word_fall_through_o;
	int                err_count = 0;
	int                compares  = 0;

	always #12.5 clk_i = ~clk_i;

	fft_flags_top i_fft_flags_top (
		.clk_i, .reset_i, .master_reset_n_i, .partial_reset_n_i, .write_clock_i,
		.read_clock_i, .write_enable_n_i, .read_enable_n_i, .offset_load_select_n_i,
		.serial_enable_n_i, .mode_serial_input_pin_i, .write_data_in_i, .read_data_out_o,
		.output_ready_n_o, .input_ready_n_o, .empty_flag_n_o, .full_flag_n_o,
		.almost_empty_flag_n_o, .almost_full_flag_n_o, .half_full_flag_n_o,
		.first_word_fall_through_o
	);

	fft_link_model i_fft_link_model (
		.clk_i,
		.write_clock_o(write_clock_i),
		.read_clock_o(read_clock_i),
		.write_enable_n_o(write_enable_n_i),
		.read_enable_n_o(read_enable_n_i),
		.offset_load_select_n_o(offset_load_select_n_i),
		.serial_enable_n_o(serial_enable_n_i),
		.serial_input_o(mode_serial_input_pin_i),
		.write_data_o(write_data_in_i)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Timing mode and all status flags in one word
	function automatic logic [DATA_W-1:0] flags();
		return {1'b0, first_word_fall_through_o, output_ready_n_o, input_ready_n_o,
			empty_flag_n_o, full_flag_n_o, almost_empty_flag_n_o, almost_full_flag_n_o,
			half_full_flag_n_o};
	endfunction

	function automatic logic [DATA_W-1:0] word(input int k);
		return 9'(k * 37 + 5);
	endfunction

	task automatic mreset(input logic ld_n, input logic si);
		i_fft_link_model.setup(ld_n, si);
		master_reset_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		master_reset_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask

	task automatic off_rd(input logic [DATA_W-1:0] exp);
		i_fft_link_model.pulse(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 9'h000);
		check(read_data_out_o, exp);
	endtask

	// Writes or reads back all four offset registers in order
	task automatic off_all(input logic [OFF_W-1:0] e, input logic [OFF_W-1:0] f,
		input logic wr);
		logic [DATA_W-1:0] v [4];
		v = '{e[8:0], {4'h0, e[13:9]}, f[8:0], {4'h0, f[13:9]}};
		for (int i = 0; i < 4; i++) begin
			if (wr) begin
				i_fft_link_model.pulse(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, v[i]);
			end else begin
				off_rd(v[i]);
			end
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_parallel();
		mreset(1'b0, 1'b1);
		check(flags(), 9'h0DB);
		off_all(OFF_DEF_PAR, OFF_DEF_PAR, 1'b0);
		off_all(14'h0002, 14'h3FFC, 1'b1);
		off_all(14'h0002, 14'h3FFC, 1'b0);
	endtask

	task automatic t_partial();
		off_rd(9'h002);
		off_rd(9'h000);
		partial_reset_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		partial_reset_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		off_rd(9'h1FC);
		off_rd(9'h01F);
	endtask

	task automatic t_first_word_fall_through_fill();
		for (int k = 1; k <= 5; k++) begin
			i_fft_link_model.pulse(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, word(k));
			if (k == 1) begin
				repeat (2) i_fft_link_model.pulse(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000);
				check(flags(), 9'h0DB);
				i_fft_link_model.pulse(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000);
				check(read_data_out_o, word(1));
			end
			check(flags(), k < 4 ? 9'h09B : (k == 4 ? 9'h09F : 9'h09D));
		end
	endtask

	task automatic t_first_word_fall_through_drain();
		logic [DATA_W-1:0] held;
		for (int k = 1; k <= 5; k++) begin
			i_fft_link_model.pulse(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 9'h000);
			if (k < 5) begin
				check(read_data_out_o, word(k + 1));
			end
			check(flags(), k == 1 ? 9'h09F : (k < 5 ? 9'h09B : 9'h0DB));
		end
		held = read_data_out_o;
		i_fft_link_model.pulse(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 9'h000);
		check(read_data_out_o, held);
		check(flags(), 9'h0DB);
	endtask

	task automatic t_serial();
		logic [27:0] bits;
		bits = {14'h0009, 14'h0005};
		mreset(1'b1, 1'b0);
		check(flags(), 9'h06B);
		off_all(OFF_DEF_SER, OFF_DEF_SER, 1'b0);
		for (int i = 0; i < 28; i++) begin
			i_fft_link_model.pulse(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, bits[i], 9'h000);
		end
		off_all(14'h0005, 14'h0009, 1'b0);
		off_all(14'h000A, 14'h000B, 1'b1);
		off_all(14'h0005, 14'h0009, 1'b0);
	endtask

	task automatic t_std_word();
		i_fft_link_model.pulse(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 9'h0C3);
		repeat (2) i_fft_link_model.pulse(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000);
		check(flags(), 9'h07B);
		i_fft_link_model.pulse(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 9'h000);
		check(read_data_out_o, 9'h0C3);
		check(flags(), 9'h06B);
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_parallel();
		t_partial();
		t_first_word_fall_through_fill();
		t_first_word_fall_through_drain();
		t_serial();
		t_std_word();
		print_verdict();
	end

	// Watchdog well beyond the expected run of about 680 cycles
	initial begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule // fft_flags_top_tb
